// ==== comparator_control_defines.vh ====
// Register offsets, field positions, source codes and reset values of the comparator control logic.
`ifndef COMPARATOR_CONTROL_DEFINES_VH
`define COMPARATOR_CONTROL_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_COMPARATOR_CONTROL          5'h00
`define ADDR_COMPARATOR_REFERENCE_SELECT 5'h04
`define ADDR_TIMER2_SCALE                5'h08
`define ADDR_OPTION                      5'h0c
`define ADDR_IRQ_STATUS                  5'h10
`define ADDR_IRQ_MASK                    5'h14

// ----------------------------------------
// Comparator control fields
// ----------------------------------------
`define CC_ENABLE     7
`define CC_RESULT     6
`define CC_POLARITY   4
`define CC_NEG_HI     3
`define CC_NEG_LO     1
`define CC_POS        0
`define CC_WRITE_MASK 8'hbf

// ----------------------------------------
// Reference select fields
// ----------------------------------------
`define RS_PIN_OUT   7
`define RS_RANGE_HI  5
`define RS_RANGE_LO  4
`define RS_STEP_HI   3
`define RS_STEP_LO   0

// ----------------------------------------
// Inverting input source codes
// ----------------------------------------
`define NEG_LINE_3   3'h0
`define NEG_LINE_4   3'h1
`define NEG_BANDGAP  3'h2
`define NEG_LADDER   3'h3
`define NEG_B_LINE_6 3'h4
`define NEG_B_LINE_7 3'h5

// ----------------------------------------
// Timer2 scale and option fields
// ----------------------------------------
`define T2_PRE_HI      6
`define T2_PRE_LO      5
`define T2_DIV_HI      4
`define T2_DIV_LO      0
`define OPT_SAMPLED    0
`define OPT_GATED_PWM  1

// ----------------------------------------
// Interrupt bits and reset values
// ----------------------------------------
`define IRQ_RISE       0
`define IRQ_FALL       1
`define RESET_BYTE     8'h00
`define SEL_NONE       6'h00
`endif

// ==== comparator_control_logic.v ====
// Digital control around the analog comparator: input select, ladder code, result path, interrupt.
// ----------------------------------------
// Overview of operation
// ----------------------------------------
// Overview of operation
// - Three-bit field routes one of six sources to the inverting input.
// - Bit zero selects port pin or ladder for the non-inverting input.
// - Control pattern 1_0_0_000_0 enables, inverting line 3, non-inverting ladder.
// - Pattern 1_0_0_1_011_1 enables, inverts, ladder inverting, line 4 non-inverting.
// - Reference-select top bit forces the result onto port line 0 regardless direction.
// - Result goes out directly or sampled on the Timer2 divided clock.
// - Polarity bit inverts result for readable bit, pin and interrupt.
// - Result readable as read-only control bit and raises an interrupt.
// - Two-bit range picks ladder limits; four-bit step picks one of sixteen.
// - Range 00 gives supply/4 plus (step+1)/32 of supply.
// - Range 10 gives supply/5 plus (step+1)/40 of supply.
// - Sampling clock follows Timer2 prescaler and divide-by-one-to-thirty-two scaler.
// - Gated PWM option stops PWM while result is high, resumes when low.
`timescale 1ns/1ps
`include "comparator_control_defines.vh"

module comparator_control_logic (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [4:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        comparator_raw,
	input  wire        timer2_pwm_in,
	output reg         comparator_enable,
	output reg  [5:0]  negative_select,
	output reg         positive_select_ladder,
	output reg  [1:0]  ladder_range,
	output reg  [3:0]  ladder_step,
	output reg         port_a_line_0_out,
	output reg         port_a_line_0_force,
	output reg         timer2_divided_clock,
	output reg         timer2_pwm_out,
	output reg         irq
);

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	reg  [7:0] comparator_control;
	reg  [7:0] comparator_reference_select;
	reg  [7:0] timer2_scale;
	reg  [1:0] option;
	reg  [1:0] irq_status;
	reg  [1:0] irq_mask;
	reg  [5:0] prescale_count;
	reg  [4:0] scale_count;
	reg        sample_stage_1;
	reg        sample_stage_2;
	reg        result_prev;
	reg  [31:0] next_read;
	reg  [5:0] next_prescale;
	reg  [4:0] next_scale;
	wire       access;
	wire       write_low;
	wire       prescale_tick;
	wire       scale_tick;
	wire       polarized;
	wire       result;
	wire [1:0] rise_fall;

	// Decodes the three-bit inverting code into one select line per source.
	function [5:0] decode_negative;
		input [2:0] code;
		begin
			case (code)
				`NEG_LINE_3:   decode_negative = 6'h01;
				`NEG_LINE_4:   decode_negative = 6'h02;
				`NEG_BANDGAP:  decode_negative = 6'h04;
				`NEG_LADDER:   decode_negative = 6'h08;
				`NEG_B_LINE_6: decode_negative = 6'h10;
				`NEG_B_LINE_7: decode_negative = 6'h20;
				default:       decode_negative = `SEL_NONE;
			endcase
		end
	endfunction

	// Prescaler terminal count for the divide-by-1, 4, 16 and 64 options.
	function [5:0] prescale_limit;
		input [1:0] code;
		begin
			case (code)
				2'h0:    prescale_limit = 6'h00;
				2'h1:    prescale_limit = 6'h03;
				2'h2:    prescale_limit = 6'h0f;
				default: prescale_limit = 6'h3f;
			endcase
		end
	endfunction

	assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign write_low = access & wb_we_i & wb_sel_i[0];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			comparator_control          <= `RESET_BYTE;
			comparator_reference_select <= `RESET_BYTE;
			timer2_scale                <= `RESET_BYTE;
			option                      <= 2'h0;
			irq_mask                    <= 2'h0;
			wb_ack_o                    <= 1'b0;
			wb_dat_o                    <= 32'h0000_0000;
		end else begin
			wb_ack_o <= access;
			if (access)
				wb_dat_o <= next_read;
			if (write_low) begin
				case (wb_adr_i)
					`ADDR_COMPARATOR_CONTROL: begin
						// The result bit is read-only; writes never reach it.
						comparator_control <= wb_dat_i[7:0] & `CC_WRITE_MASK;
					end
					`ADDR_COMPARATOR_REFERENCE_SELECT: begin
						comparator_reference_select <= wb_dat_i[7:0];
					end
					`ADDR_TIMER2_SCALE: begin
						timer2_scale <= wb_dat_i[7:0];
					end
					`ADDR_OPTION: begin
						option <= wb_dat_i[1:0];
					end
					`ADDR_IRQ_MASK: begin
						irq_mask <= wb_dat_i[1:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Read mux; unmapped addresses answer with zero.
	always @* begin
		next_read = 32'h0000_0000;
		case (wb_adr_i)
			`ADDR_COMPARATOR_CONTROL: begin
				next_read[7:0] = comparator_control;
				next_read[`CC_RESULT] = result;
			end
			`ADDR_COMPARATOR_REFERENCE_SELECT: next_read[7:0] = comparator_reference_select;
			`ADDR_TIMER2_SCALE:                next_read[7:0] = timer2_scale;
			`ADDR_OPTION:                      next_read[1:0] = option;
			`ADDR_IRQ_STATUS:                  next_read[1:0] = irq_status;
			`ADDR_IRQ_MASK:                    next_read[1:0] = irq_mask;
			default:                           next_read = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Timer2 divided clock
	// ----------------------------------------
	// The sampling rate is a one-cycle enable, so the block keeps a single clock.
	assign prescale_tick = (prescale_count == prescale_limit(timer2_scale[`T2_PRE_HI:`T2_PRE_LO]));
	assign scale_tick    = prescale_tick & (scale_count == timer2_scale[`T2_DIV_HI:`T2_DIV_LO]);

	always @* begin
		next_prescale = prescale_tick ? 6'h00 : prescale_count + 6'h01;
		next_scale    = scale_count;
		if (prescale_tick)
			next_scale = scale_tick ? 5'h00 : scale_count + 5'h01;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale_count       <= 6'h00;
			scale_count          <= 5'h00;
			timer2_divided_clock <= 1'b0;
		end else begin
			prescale_count       <= next_prescale;
			scale_count          <= next_scale;
			timer2_divided_clock <= scale_tick;
		end
	end

	// ----------------------------------------
	// Result path
	// ----------------------------------------
	assign polarized = comparator_raw ^ comparator_control[`CC_POLARITY];

	// Two stages guard against the asynchronous analog edge in sampled mode.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_stage_1 <= 1'b0;
			sample_stage_2 <= 1'b0;
		end else if (timer2_divided_clock) begin
			sample_stage_1 <= polarized;
			sample_stage_2 <= sample_stage_1;
		end
	end

	assign result = option[`OPT_SAMPLED] ? sample_stage_2 : polarized;
	assign rise_fall = {result_prev & ~result, ~result_prev & result};

	// ----------------------------------------
	// Analog control and pin outputs
	// ----------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			comparator_enable      <= 1'b0;
			negative_select        <= `SEL_NONE;
			positive_select_ladder <= 1'b0;
			ladder_range           <= 2'h0;
			ladder_step            <= 4'h0;
			port_a_line_0_out      <= 1'b0;
			port_a_line_0_force    <= 1'b0;
			timer2_pwm_out         <= 1'b0;
			result_prev            <= 1'b0;
		end else begin
			comparator_enable      <= comparator_control[`CC_ENABLE];
			negative_select        <= decode_negative(comparator_control[`CC_NEG_HI:`CC_NEG_LO]);
			// Bit clear selects the ladder; set selects port line 4.
			positive_select_ladder <= ~comparator_control[`CC_POS];
			// The analog ladder forms the voltages of ranges 00 and 10 from these codes.
			ladder_range <= comparator_reference_select[`RS_RANGE_HI:`RS_RANGE_LO];
			ladder_step  <= comparator_reference_select[`RS_STEP_HI:`RS_STEP_LO];
			port_a_line_0_out      <= result;
			port_a_line_0_force    <= comparator_reference_select[`RS_PIN_OUT];
			timer2_pwm_out <= timer2_pwm_in & ~(option[`OPT_GATED_PWM] & result);
			result_prev    <= result;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// A new edge in the clearing cycle wins, so no event is lost.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_status <= 2'h0;
			irq        <= 1'b0;
		end else begin
			if (write_low && wb_adr_i == `ADDR_IRQ_STATUS)
				irq_status <= (irq_status & ~wb_dat_i[1:0]) | rise_fall;
			else
				irq_status <= irq_status | rise_fall;
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule // comparator_control_logic

// ==== comparator_control_chk.sv ====
// Port assertions for the comparator control logic.
`timescale 1ns/1ps
module comparator_control_chk (
	input wire        clk,
	input wire        rst_b,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [4:0]  wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        comparator_enable,
	input wire [5:0]  negative_select,
	input wire        positive_select_ladder,
	input wire [1:0]  ladder_range,
	input wire [3:0]  ladder_step,
	input wire        port_a_line_0_force
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Only the first cycle of a request counts, so a held request is not taken twice.
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_cc = req && wb_we_i && wb_adr_i == 5'h00;
	wire wr_rs = req && wb_we_i && wb_adr_i == 5'h04;
	property p_ack; req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_en; wr_cc |-> ##2 comparator_enable == $past(wb_dat_i[7], 2); endproperty
	a_en: assert property (p_en) else $error("enable wrong");
	property p_neg; wr_cc |-> ##2 negative_select ==
		($past(wb_dat_i[3:1], 2) > 3'h5 ? 6'h00 : 6'h01 << $past(wb_dat_i[3:1], 2)); endproperty
	a_neg: assert property (p_neg) else $error("minus select wrong");
	property p_pos; wr_cc |-> ##2 positive_select_ladder != $past(wb_dat_i[0], 2); endproperty
	a_pos: assert property (p_pos) else $error("plus select wrong");
	property p_ref; wr_rs |-> ##2 {port_a_line_0_force, ladder_range, ladder_step} ==
		{$past(wb_dat_i[7], 2), $past(wb_dat_i[5:0], 2)}; endproperty
	a_ref: assert property (p_ref) else $error("reference fields wrong");
	property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i > 5'h14 |-> wb_dat_o == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	c_cc: cover property (wr_cc);
	c_rs: cover property (wr_rs);
	c_unmap: cover property (wb_ack_o && wb_adr_i > 5'h14);
endmodule // comparator_control_chk
bind comparator_control_logic comparator_control_chk chk (.*);

// ==== comparator_analog_model.sv ====
// Behavioural comparator core, reference ladder and port pin levels.
`timescale 1ns/1ps
module comparator_analog_model #(
	parameter int BANDGAP    = 60,
	parameter int LADDER_ALT = 64
) (
	input  wire logic       clk,
	input  wire logic       comparator_enable,
	input  wire logic [5:0] negative_select,
	input  wire logic       positive_select_ladder,
	input  wire logic [1:0] ladder_range,
	input  wire logic [3:0] ladder_step,
	input  wire logic [7:0] port_a_line_3,
	input  wire logic [7:0] port_a_line_4,
	input  wire logic [7:0] port_b_line_6,
	input  wire logic [7:0] port_b_line_7,
	output logic            comparator_raw
);
	// ----------------------------------------
	// Levels in 1/160 of supply, exact for both documented ranges
	// ----------------------------------------
	int ladder;
	int minus;
	always_comb begin
		ladder = ladder_range == 2'h0 ? 40 + 5 * (ladder_step + 1) :
			ladder_range == 2'h2 ? 32 + 4 * (ladder_step + 1) : LADDER_ALT;
		case (negative_select)
			6'h01: minus = port_a_line_3;
			6'h02: minus = port_a_line_4;
			6'h04: minus = BANDGAP;
			6'h08: minus = ladder;
			6'h10: minus = port_b_line_6;
			6'h20: minus = port_b_line_7;
			default: minus = 255;
		endcase
	end
	always_ff @(posedge clk)
		comparator_raw <= comparator_enable && (positive_select_ladder ? ladder : port_a_line_4) > minus;
endmodule // comparator_analog_model

// ==== comparator_control_logic_bench.sv ====
// Self-checking bench for the comparator control logic.
`timescale 1ns/1ps
module comparator_control_logic_bench;
	logic        clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic        timer2_pwm_in = 1'b0, p;
	logic [4:0]  wb_adr_i = 5'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [7:0]  port_a_line_3 = 8'h00, port_a_line_4 = 8'h00, port_b_line_6 = 8'h00, port_b_line_7 = 8'h00;
	wire  [31:0] wb_dat_o;
	wire  [5:0]  negative_select;
	wire  [1:0]  ladder_range;
	wire  [3:0]  ladder_step;
	wire         wb_ack_o, comparator_raw, comparator_enable, positive_select_ladder, port_a_line_0_out;
	wire         port_a_line_0_force, timer2_divided_clock, timer2_pwm_out, irq;
	logic [31:0] exp_q[$];
	int          num_errors = 0, comparisons = 0, k, s, v;
	comparator_control_logic dut (.*);
	comparator_analog_model model (.*);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			num_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h00_0000, d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] want);
		exp_q.push_back({24'h00_0000, want});
		wb(1'b0, a, 8'h00);
	endtask
	task automatic lv(input logic [7:0] x, input logic [7:0] y);
		{port_a_line_3, port_a_line_4} <= {x, y};
		repeat (5) @(posedge clk);
	endtask
	task automatic pulse();
		do @(posedge clk); while (timer2_divided_clock !== 1'b1);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Reads are judged where the answer appears, not where they are issued.
	always @(posedge clk) if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) check(wb_dat_o, exp_q.pop_front());
	initial forever #2.5 clk = ~clk;
	initial begin
		#300000;
		num_errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(18538));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 28; a += 4) rd(a[4:0], 8'h00);
		wb(1'b1, 5'h18, 8'hff);
		rd(5'h18, 8'h00);
		$display("reset and map test done");
		wb(1'b1, 5'h04, 8'h09);
		wb(1'b1, 5'h00, 8'h80);
		lv(8'd80, 8'd0);
		rd(5'h00, 8'hc0);
		check({negative_select, positive_select_ladder, ladder_range, ladder_step}, 13'h00c9);
		lv(8'd100, 8'd0);
		rd(5'h00, 8'h80);
		wb(1'b1, 5'h04, 8'had);
		wb(1'b1, 5'h00, 8'h97);
		lv(8'd0, 8'd100);
		rd(5'h00, 8'h97);
		check({port_a_line_0_force, port_a_line_0_out}, 2'h2);
		lv(8'd0, 8'd70);
		rd(5'h00, 8'hd7);
		check({port_a_line_0_force, port_a_line_0_out}, 2'h3);
		wb(1'b1, 5'h00, 8'hef);
		rd(5'h00, 8'haf);
		for (int c = 0; c < 8; c++) begin
			wb(1'b1, 5'h00, {4'h8, c[2:0], 1'b0});
			check(negative_select, c < 6 ? 1 << c : 0);
		end
		$display("select test done");
		wb(1'b1, 5'h00, 8'h80);
		lv(8'd100, 8'd0);
		wb(1'b1, 5'h10, 8'h03);
		wb(1'b1, 5'h14, 8'h01);
		lv(8'd80, 8'd0);
		check(irq, 1'b1);
		rd(5'h10, 8'h01);
		wb(1'b1, 5'h14, 8'h00);
		check(irq, 1'b0);
		wb(1'b1, 5'h14, 8'h01);
		check(irq, 1'b1);
		wb(1'b1, 5'h10, 8'h01);
		check(irq, 1'b0);
		$display("interrupt test done");
		wb(1'b1, 5'h0c, 8'h01);
		for (int i = 0; i < 3; i++) begin
			s = $urandom_range(7);
			wb(1'b1, 5'h08, {1'b0, i[1:0], s[4:0]});
			pulse();
			pulse();
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (timer2_divided_clock !== 1'b1 && k < 2000);
			check(k, (4 ** i) * (s + 1));
		end
		pulse();
		lv(8'd100, 8'd0);
		check(port_a_line_0_out, 1'b1);
		repeat (300) @(posedge clk);
		check(port_a_line_0_out, 1'b0);
		$display("sampled test done");
		wb(1'b1, 5'h0c, 8'h02);
		repeat (8) begin
			v = $urandom_range(120, 60);
			p = 1'($urandom_range(1));
			timer2_pwm_in <= p;
			lv(v[7:0], 8'd0);
			check(timer2_pwm_out, p && v >= 88);
		end
		$display("gated pwm test done");
		wb(1'b1, 5'h00, 8'h84);
		for (int n = 0; n < 16; n++) begin
			wb(1'b1, 5'h04, n[7:0]);
			rd(5'h00, ((40 + 5 * (n + 1)) > 60) ? 8'hc4 : 8'h84);
		end
		$display("supply sweep test done");
		end_of_test();
	end
endmodule // comparator_control_logic_bench
